/* File: board_clock_source.sv */
module board_clock_source #(
	parameter int HOST_HALF = 4,
	parameter int PCI_HALF  = 6
) (
	input  wire logic clk,
	input  wire logic agent_mode,
	output logic      host_input_clock,
	output logic      pci_input_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	int   hc  = 0;
	int   pc  = 0;
	logic hcl = 1'b0;
	logic pcl = 1'b0;
	assign host_input_clock = hcl;
	assign pci_input_clock  = pcl;
	// Host oscillator tied low on an agent board
	always @(posedge clk) begin
		hc <= (hc == HOST_HALF - 1) ? 0 : hc + 1;
		pc <= (pc == PCI_HALF - 1) ? 0 : pc + 1;
		if (agent_mode)
			hcl <= 1'b0;
		else if (hc == HOST_HALF - 1)
			hcl <= ~hcl;
		if (pc == PCI_HALF - 1)
			pcl <= ~pcl;
	end
endmodule : board_clock_source

/* File: clock_gen_pkg.sv */
package clock_gen_pkg;
	// Output and unit counts
	localparam int PCI_OUT_COUNT = 5;
	localparam int UNIT_COUNT    = 6;
	localparam int PCI_DMA_UNIT  = 5;

	// Unit ratio codes
	localparam int         RATIO_W     = 2;
	localparam logic [1:0] RATIO_OFF   = 2'h0;
	localparam logic [1:0] RATIO_FULL  = 2'h1;
	localparam logic [1:0] RATIO_HALF  = 2'h2;
	localparam logic [1:0] RATIO_THIRD = 2'h3;
	// Unit 5 full rate, units 0..4 one third
	localparam logic [11:0] UNIT_RATIO_RESET = 12'h7ff;

	// Reset configuration word layout
	localparam int RCW_LB_BIT     = 0;
	localparam int RCW_MEM_BIT    = 1;
	localparam int RCW_SYSMUL_LSB = 4;
	localparam int RCW_SYSMUL_W   = 4;
	localparam int RCW_CORE_LSB   = 8;
	localparam int RCW_CORE_W     = 7;
	localparam logic [4:0] SYSMUL_ZERO_FACTOR = 5'h10;

	// Built-in reset options, selected by reset source 1..3
	localparam logic [31:0] BUILTIN_RCW_1 = 32'h0000_0240;
	localparam logic [31:0] BUILTIN_RCW_2 = 32'h0000_0461;
	localparam logic [31:0] BUILTIN_RCW_3 = 32'h0000_0683;

	// Local bus divide field codes
	localparam logic [3:0] LB_DIV2 = 4'h2;
	localparam logic [3:0] LB_DIV4 = 4'h4;
	localparam logic [3:0] LB_DIV8 = 4'h8;
endpackage : clock_gen_pkg

/* File: system_clock_generation.sv */
// Behaviour
// - Host mode takes host input clock as primary; agent mode the PCI input.
// - Primary clock feeds a divide-by-two and the PCI output muxes.
// - Sync output is primary clock or its half, per input divide strap level.
// - Each PCI output clock picks full or half rate by its select bit.
// - System ratio is (1 + strap) times the system multiplier field, a field of 0 counting as 16.
// - Core clock ratio comes from the config word's core multiplier field.
// - Multipliers come from the word captured at reset or a built-in option.
// - Memory clock is system clock times (1 + ratio); bus pair is its half.
// - Local bus clock is system clock times (1 + ratio), then divided.
// - Unit ratios reprogrammable after reset; defaults hold until written.
// - Units 0..4 default one third, any of four rates; PCI-DMA default full, off or full.
module system_clock_generation
	import clock_gen_pkg::*;
#(
	parameter int PCI_OUTS = PCI_OUT_COUNT,
	parameter int UNITS    = UNIT_COUNT
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 pci_host_mode,
	input  wire logic                 host_input_clock,
	input  wire logic                 pci_input_clock,
	input  wire logic                 input_divide_strap,
	input  wire logic [31:0]          reset_config_word_low,
	input  wire logic [1:0]           reset_source_sel,
	input  wire logic [PCI_OUTS-1:0]  output_clock_control_reg,
	input  wire logic [3:0]           local_bus_clock_reg,
	input  wire logic                 unit_ratio_write,
	input  wire logic [2*UNITS-1:0]   unit_ratio_wdata,
	output logic                      primary_clock,
	output logic                      pci_sync_output,
	output logic [PCI_OUTS-1:0]       pci_output_clock_n,
	output logic [3:0]                system_multiplier_field,
	output logic [5:0]                system_ratio,
	output logic [6:0]                core_multiplier_field,
	output logic                      memory_ratio_field,
	output logic                      local_bus_ratio_field,
	output logic                      memory_bus_clock_p,
	output logic                      memory_bus_clock_n,
	output logic [2:0]                local_bus_clock_outputs,
	output logic                      local_bus_sync_output,
	output logic [2*UNITS-1:0]        unit_clock_ratio_reg,
	output logic [UNITS-1:0]          unit_clock_enable
);

	function automatic logic [4:0] sysmul_factor(input logic [3:0] f);
		sysmul_factor = (f == 4'h0) ? SYSMUL_ZERO_FACTOR : {1'b0, f};
	endfunction : sysmul_factor

	function automatic logic [1:0] ratio_period(input logic [1:0] r);
		case (r)
			RATIO_HALF:  ratio_period = 2'h2;
			RATIO_THIRD: ratio_period = 2'h3;
			default:     ratio_period = 2'h1;
		endcase
	endfunction : ratio_period

	function automatic logic [2:0] lb_half(input logic [3:0] d);
		case (d)
			LB_DIV4: lb_half = 3'h2;
			LB_DIV8: lb_half = 3'h4;
			default: lb_half = 3'h1;
		endcase
	endfunction : lb_half

	// Reset configuration capture
	logic [31:0] rcw;
	logic        strap_at_reset;
	logic [31:0] next_rcw;
	logic        next_strap_at_reset;

	always_comb begin
		next_rcw = rcw;
		next_strap_at_reset = strap_at_reset;
		if (!rst_b) begin
			next_strap_at_reset = input_divide_strap;
			case (reset_source_sel)
				2'h1:    next_rcw = BUILTIN_RCW_1;
				2'h2:    next_rcw = BUILTIN_RCW_2;
				2'h3:    next_rcw = BUILTIN_RCW_3;
				default: next_rcw = reset_config_word_low;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		rcw <= next_rcw;
		strap_at_reset <= next_strap_at_reset;
	end

	assign system_multiplier_field = rcw[RCW_SYSMUL_LSB +: RCW_SYSMUL_W];
	assign core_multiplier_field   = rcw[RCW_CORE_LSB +: RCW_CORE_W];
	assign memory_ratio_field      = rcw[RCW_MEM_BIT];
	assign local_bus_ratio_field   = rcw[RCW_LB_BIT];
	// Ratio of system clock to sync input
	assign system_ratio = strap_at_reset
		? {sysmul_factor(system_multiplier_field), 1'b0}
		: {1'b0, sysmul_factor(system_multiplier_field)};

	// Primary clock and PCI outputs
	logic                primary_prev;
	logic                primary_half;
	logic                next_primary;
	logic                next_primary_half;
	logic                next_sync;
	logic [PCI_OUTS-1:0] next_pci_out;

	always_comb begin
		next_primary = pci_host_mode ? host_input_clock : pci_input_clock;
		next_primary_half = primary_half;
		if (primary_clock && !primary_prev)
			next_primary_half = ~primary_half;
		next_sync = input_divide_strap ? primary_half : primary_clock;
		for (int i = 0; i < PCI_OUTS; i++) begin
			next_pci_out[i] = output_clock_control_reg[i] ? primary_half
				: primary_clock;
		end
		if (!rst_b) begin
			next_primary = 1'b0;
			next_primary_half = 1'b0;
			next_sync = 1'b0;
			next_pci_out = '0;
		end
	end

	always_ff @(posedge clk) begin
		primary_clock <= next_primary;
		primary_prev <= primary_clock;
		primary_half <= next_primary_half;
		pci_sync_output <= next_sync;
		pci_output_clock_n <= next_pci_out;
	end

	// Reference runs at twice the system bus clock; csb_tick marks its edges
	logic csb_phase;
	logic next_csb_phase;
	logic csb_tick;
	logic ddr_tick;
	logic lbiu_tick;

	assign next_csb_phase = rst_b ? ~csb_phase : 1'b0;
	assign csb_tick  = csb_phase;
	assign ddr_tick  = memory_ratio_field | csb_tick;
	assign lbiu_tick = local_bus_ratio_field | csb_tick;

	always_ff @(posedge clk) begin
		csb_phase <= next_csb_phase;
	end

	// Memory bus clock pair
	logic next_mem_clk;

	always_comb begin
		next_mem_clk = memory_bus_clock_p;
		if (ddr_tick)
			next_mem_clk = ~memory_bus_clock_p;
		if (!rst_b)
			next_mem_clk = 1'b0;
	end

	always_ff @(posedge clk) begin
		memory_bus_clock_p <= next_mem_clk;
		memory_bus_clock_n <= ~next_mem_clk;
	end

	// Local bus divider; field sampled only at a half-period boundary
	logic [2:0] lb_cnt;
	logic       lb_clk;
	logic [2:0] next_lb_cnt;
	logic       next_lb_clk;

	always_comb begin
		next_lb_cnt = lb_cnt;
		next_lb_clk = lb_clk;
		if (lbiu_tick) begin
			if (lb_cnt == 3'h0) begin
				next_lb_clk = ~lb_clk;
				next_lb_cnt = lb_half(local_bus_clock_reg) - 3'h1;
			end else begin
				next_lb_cnt = lb_cnt - 3'h1;
			end
		end
		if (!rst_b) begin
			next_lb_cnt = 3'h0;
			next_lb_clk = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		lb_cnt <= next_lb_cnt;
		lb_clk <= next_lb_clk;
	end

	assign local_bus_clock_outputs = {3{lb_clk}};
	assign local_bus_sync_output   = lb_clk;

	// Unit ratio register
	logic [2*UNITS-1:0] next_ratio_reg;

	always_comb begin
		next_ratio_reg = unit_clock_ratio_reg;
		if (unit_ratio_write) begin
			next_ratio_reg = unit_ratio_wdata;
			// PCI and DMA complex: off or full only
			next_ratio_reg[2*PCI_DMA_UNIT +: 2] =
				{1'b0, unit_ratio_wdata[2*PCI_DMA_UNIT]};
		end
		if (!rst_b)
			next_ratio_reg = UNIT_RATIO_RESET[2*UNITS-1:0];
	end

	always_ff @(posedge clk) begin
		unit_clock_ratio_reg <= next_ratio_reg;
	end

	// Per-unit enable pulse; new ratio adopted only at end of a period
	for (genvar u = 0; u < UNITS; u++) begin : g_unit
		logic [1:0] cnt;
		logic [1:0] next_cnt;
		logic       next_en;
		logic [1:0] req;

		assign req = unit_clock_ratio_reg[2*u +: 2];

		always_comb begin
			next_cnt = cnt;
			next_en = 1'b0;
			if (csb_tick) begin
				if (cnt == 2'h0) begin
					next_cnt = ratio_period(req) - 2'h1;
					next_en = (req != RATIO_OFF);
				end else begin
					next_cnt = cnt - 2'h1;
				end
			end
			if (!rst_b) begin
				next_cnt = 2'h0;
				next_en = 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			cnt <= next_cnt;
			unit_clock_enable[u] <= next_en;
		end

		a_unit_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
			(cnt == 2'h0 && csb_tick && req == RATIO_OFF) |=> !unit_clock_enable[u])
			else $error("gated unit pulsed");
		a_unit_third_gap: assert property (@(posedge clk) disable iff (!rst_b)
			(unit_clock_enable[u] && $past(req) == RATIO_THIRD)
			|=> !unit_clock_enable[u] [*5])
			else $error("third-rate unit pulsed too soon");
	end

	sequence s_primary_rise;
		primary_clock && !primary_prev;
	endsequence

	a_primary_host: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && $past(pci_host_mode)
		|-> primary_clock == $past(host_input_clock))
		else $error("primary clock not host input");
	a_half_toggle: assert property (@(posedge clk) disable iff (!rst_b)
		s_primary_rise |=> primary_half != $past(primary_half))
		else $error("half clock missed toggle");
	a_sync_select: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && $past(input_divide_strap)
		|-> pci_sync_output == $past(primary_half))
		else $error("sync output not half rate");
	a_pci_out_full: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && !$past(output_clock_control_reg[0])
		|-> pci_output_clock_n[0] == $past(primary_clock))
		else $error("pci output not full rate");
	a_sys_ratio: assert property (@(posedge clk) disable iff (!rst_b)
		strap_at_reset && system_multiplier_field == 4'h5 |-> system_ratio == 6'h0a)
		else $error("system ratio wrong");
	a_mem_pair: assert property (@(posedge clk) disable iff (!rst_b)
		memory_ratio_field |=> memory_bus_clock_p != $past(memory_bus_clock_p)
		&& memory_bus_clock_n == !memory_bus_clock_p)
		else $error("memory clock pair wrong");
	a_reset_ratio: assert property (@(posedge clk)
		!rst_b |=> unit_clock_ratio_reg == UNIT_RATIO_RESET[2*UNITS-1:0])
		else $error("unit ratios not default after reset");
	a_pci_dma_full: assert property (@(posedge clk) disable iff (!rst_b)
		unit_clock_ratio_reg[2*PCI_DMA_UNIT+1] == 1'b0)
		else $error("pci dma ratio illegal");
	a_lb_div2: assert property (@(posedge clk) disable iff (!rst_b)
		local_bus_ratio_field && local_bus_clock_reg == LB_DIV2 && lb_cnt == 3'h0
		|=> lb_clk != $past(lb_clk))
		else $error("local bus clock missed toggle");

endmodule : system_clock_generation

/* File: system_clock_generation_tb_top.sv */
module system_clock_generation_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import clock_gen_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, host = 1'b1, hclk, pclk;
	logic        strap = 1'b0, wr = 1'b0, pri, sync, mp, mn, lsync;
	logic [31:0] word = 32'h0;
	logic [1:0]  src = 2'h0;
	logic [4:0]  out_ctl = 5'h0, pci;
	logic [3:0]  lb_ctl = 4'h2, sysmul;
	logic [11:0] wdata = 12'h0, ratios;
	logic [5:0]  sratio, en;
	logic [6:0]  core;
	logic        memf, lbf;
	logic [2:0]  lbo;
	logic        win = 1'b0;
	logic [12:0] prev;
	int num_errors = 0, compares = 0, cycles = 0;
	int t_pri, t_sync, t_p0, t_p1, t_mem, t_lb, e0, e5, bad;
	always #25 clk = ~clk;
	board_clock_source i_board_clock_source (.clk(clk), .agent_mode(~host),
		.host_input_clock(hclk), .pci_input_clock(pclk));
	system_clock_generation i_system_clock_generation (.clk(clk),
		.rst_b(rst_b), .pci_host_mode(host), .host_input_clock(hclk),
		.pci_input_clock(pclk), .input_divide_strap(strap),
		.reset_config_word_low(word), .reset_source_sel(src),
		.output_clock_control_reg(out_ctl), .local_bus_clock_reg(lb_ctl),
		.unit_ratio_write(wr), .unit_ratio_wdata(wdata),
		.primary_clock(pri), .pci_sync_output(sync),
		.pci_output_clock_n(pci), .system_multiplier_field(sysmul),
		.system_ratio(sratio), .core_multiplier_field(core),
		.memory_ratio_field(memf), .local_bus_ratio_field(lbf),
		.memory_bus_clock_p(mp), .memory_bus_clock_n(mn),
		.local_bus_clock_outputs(lbo), .local_bus_sync_output(lsync),
		.unit_clock_ratio_reg(ratios), .unit_clock_enable(en));
	task automatic finish_test();
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] near(input int a, input int b);
		return {31'h0, (a >= b - 2) && (a <= b + 2)};
	endfunction : near
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test();
		end
		prev <= {pri, sync, pci[1:0], mp, lbo[0], en[0], 6'h0};
		if (!win) begin
			{t_pri, t_sync, t_p0, t_p1, t_mem, t_lb, e0, e5, bad} = '0;
		end else begin
			t_pri += int'(pri != prev[12]);
			t_sync += int'(sync != prev[11]);
			t_p0 += int'(pci[0] != prev[9]);
			t_p1 += int'(pci[1] != prev[10]);
			t_mem += int'(mp != prev[8]);
			t_lb += int'(lbo[0] != prev[7]);
			e0 += int'(en[0] === 1'b1);
			e5 += int'(en[5] === 1'b1);
			// Complementary pair, equal copies, no double pulse
			bad += int'(mp === mn || lbo !== {3{lsync}}
				|| pci[4:2] !== {3{pci[0]}} || en[4:1] !== {4{en[0]}}
				|| (en[0] === 1'b1 && prev[6] === 1'b1));
		end
	end
	task automatic window(input int n);
		@(posedge clk) win <= 1'b1;
		repeat (n) @(posedge clk);
		win <= 1'b0;
		#1;
	endtask : window
	task automatic do_reset(input logic [31:0] w, input logic [1:0] s,
		input logic st);
		@(posedge clk) begin
			rst_b <= 1'b0;
			word <= w;
			src <= s;
			strap <= st;
		end
		repeat (3) @(posedge clk);
		#1;
		check(ratios, UNIT_RATIO_RESET);
		check({en, mn}, 7'h01);
		@(posedge clk) rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask : do_reset
	task automatic test_config();
		do_reset(32'h0000_1353, 2'h1, 1'b0);
		check({core, sysmul, memf, lbf}, {BUILTIN_RCW_1[14:4],
			BUILTIN_RCW_1[1:0]});
		check(sratio, BUILTIN_RCW_1[7:4]);
		for (int s = 2; s < 4; s++) begin
			do_reset(32'h0000_1353, s[1:0], 1'b0);
			check({core, sysmul, memf, lbf}, s == 2 ? 13'h119 : 13'h1a3);
		end
		do_reset(32'h0000_0000, 2'h0, 1'b1);
		check(sratio, 6'h20);
		do_reset(32'h0000_1353, 2'h0, 1'b1);
		check({core, sysmul, memf, lbf}, 13'h4d7);
		check(sratio, 6'h0a);
	endtask : test_config
	task automatic test_clocks();
		@(posedge clk) begin
			strap <= 1'b0;
			out_ctl <= 5'h02;
		end
		window(96);
		check(near(t_pri, 24), 1);
		check(near(t_sync, 24), 1);
		check({near(t_p0, 24), near(t_p1, 12)}, 64'h1_0000_0001);
		@(posedge clk) strap <= 1'b1;
		window(96);
		check(near(t_sync, 12), 1);
		@(posedge clk) host <= 1'b0;
		window(96);
		check(near(t_pri, 16), 1);
		@(posedge clk) host <= 1'b1;
	endtask : test_clocks
	task automatic test_buses();
		logic [3:0] codes [4] = '{4'h2, 4'h4, 4'h8, 4'h0};
		int halves [4] = '{1, 2, 4, 1};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) lb_ctl <= codes[i];
			window(96);
			check(near(t_lb, 96 / halves[i]), 1);
			check(near(t_mem, 96), 1);
			check(bad, 0);
		end
		do_reset(32'h0, 2'h1, 1'b0);
		window(96);
		check({near(t_mem, 48), near(t_lb, 48)}, 64'h1_0000_0001);
	endtask : test_buses
	task automatic test_units();
		int per [4] = '{0, 2, 4, 6};
		window(60);
		check({near(e0, 10), near(e5, 30)}, 64'h1_0000_0001);
		for (int c = 0; c < 4; c++) begin
			// PCI-DMA stays within its ceiling at every code here
			@(posedge clk) begin
				wr <= 1'b1;
				wdata <= {6{c[1:0]}};
			end
			@(posedge clk) wr <= 1'b0;
			#1;
			check(ratios, {1'b0, c[0], {5{c[1:0]}}});
			window(60);
			check(near(e0, c ? 60 / per[c] : 0), 1);
			check(near(e5, c[0] ? 30 : 0), 1);
			check(bad, 0);
		end
	endtask : test_units
	initial begin
		test_config();
		test_clocks();
		test_buses();
		test_units();
		finish_test();
	end
endmodule : system_clock_generation_tb_top
